// >>> spims_pkg.sv
// Package: register map, field positions and shared types of the SPI port
package spims_pkg;

  // Register byte addresses (word aligned index times four)
  localparam logic [7:0] SPIMS_IDX_CTRL   = 8'hf3;
  localparam logic [7:0] SPIMS_IDX_STATUS = 8'hf4;
  localparam logic [7:0] SPIMS_IDX_DATA   = 8'hf5;
  localparam logic [7:0] SPIMS_IDX_MISC   = 8'hf6;
  localparam int unsigned SPIMS_ADDR_W    = 12;
  localparam logic [SPIMS_ADDR_W-1:0] SPIMS_ADDR_CTRL   = {2'h0, SPIMS_IDX_CTRL, 2'h0};
  localparam logic [SPIMS_ADDR_W-1:0] SPIMS_ADDR_STATUS = {2'h0, SPIMS_IDX_STATUS, 2'h0};
  localparam logic [SPIMS_ADDR_W-1:0] SPIMS_ADDR_DATA   = {2'h0, SPIMS_IDX_DATA, 2'h0};
  localparam logic [SPIMS_ADDR_W-1:0] SPIMS_ADDR_MISC   = {2'h0, SPIMS_IDX_MISC, 2'h0};

  // Control register fields
  localparam int unsigned SPIMS_C_SELECT_OUTPUT_ENABLE = 7;
  localparam int unsigned SPIMS_C_EN   = 6;
  localparam int unsigned SPIMS_C_LSB  = 5;
  localparam int unsigned SPIMS_C_MASTER_SELECT = 4;
  localparam int unsigned SPIMS_C_POL  = 3;
  localparam int unsigned SPIMS_C_PHA  = 2;
  localparam int unsigned SPIMS_C_RATE = 0;

  // Status register fields
  localparam int unsigned SPIMS_S_DONE = 7;
  localparam int unsigned SPIMS_S_WRITE_COLLISION_FLAG = 6;
  localparam int unsigned SPIMS_S_OVF  = 5;
  localparam int unsigned SPIMS_S_MODE_FAULT_FLAG = 4;
  localparam int unsigned SPIMS_S_DISM = 3;

  // Misc register fields (interrupt enables)
  localparam int unsigned SPIMS_M_PIE = 0;
  localparam int unsigned SPIMS_M_GIE = 1;

  localparam logic [7:0] SPIMS_RESET_BYTE = 8'h00;
  localparam logic [3:0] SPIMS_BITS       = 4'h8;
  localparam logic [7:0] SPIMS_ONES       = 8'hff;

  // AXI response codes
  localparam logic [1:0] SPIMS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] SPIMS_RESP_SLVERR = 2'h2;

  // Serial pin group with output enables
  typedef struct packed {
    logic sck_o;
    logic sck_oe;
    logic mosi_o;
    logic mosi_oe;
    logic miso_o;
    logic miso_oe;
    logic ss_n_o;
    logic ss_n_oe;
  } spims_pins_out_t;

  typedef struct packed {
    logic sck;
    logic mosi;
    logic miso;
    logic ss_n;
  } spims_pins_in_t;

  // Half period of the serial clock in system clocks for a rate code
  function automatic logic [6:0] spims_half_period(input logic [1:0] rate);
    unique case (rate)
      2'h0:    spims_half_period = 7'h08;
      2'h1:    spims_half_period = 7'h10;
      2'h2:    spims_half_period = 7'h20;
      default: spims_half_period = 7'h40;
    endcase
  endfunction : spims_half_period

endpackage : spims_pkg

// >>> spims_sync.sv
// Three-stage pin synchroniser; a change counts when stages two and three agree
module spims_sync
  import spims_pkg::*;
#(
  parameter int unsigned WIDTH = 4
)(
  // Clocking
  input  wire logic             clock_i,
  input  wire logic             srst_i,
  input  wire logic             ce_i,
  // Data
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] init_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] s1_reg;
  logic [WIDTH-1:0] s2_reg;
  logic [WIDTH-1:0] s3_reg;

  // Shift chain; stage one feeds only stage two
  // Reset to the idle levels of the pins so no false edge follows reset
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      s1_reg <= init_i;
      s2_reg <= init_i;
      s3_reg <= init_i;
    end
    else if (ce_i)
    begin
      s1_reg <= async_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end

  // Output follows only once two stages agree, filtering one-stage glitches
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      always_ff @(posedge clock_i)
      begin
        if (srst_i)
          sync_o[g] <= init_i[g];
        else if (ce_i && (s2_reg[g] == s3_reg[g]))
          sync_o[g] <= s3_reg[g];
      end
    end
  endgenerate
endmodule : spims_sync

// >>> spims_axil.sv
// AXI4-Lite slave front end: one write and one read at a time
module spims_axil
  import spims_pkg::*;
(
  // Clocking
  input  wire logic                    clock_i,
  input  wire logic                    srst_i,
  input  wire logic                    ce_i,
  // AXI write
  input  wire logic [SPIMS_ADDR_W-1:0] awaddr_i,
  input  wire logic                    awvalid_i,
  output logic                         awready_o,
  input  wire logic [31:0]             wdata_i,
  input  wire logic [3:0]              wstrb_i,
  input  wire logic                    wvalid_i,
  output logic                         wready_o,
  output logic [1:0]                   bresp_o,
  output logic                         bvalid_o,
  input  wire logic                    bready_i,
  // AXI read
  input  wire logic [SPIMS_ADDR_W-1:0] araddr_i,
  input  wire logic                    arvalid_i,
  output logic                         arready_o,
  output logic [31:0]                  rdata_o,
  output logic [1:0]                   rresp_o,
  output logic                         rvalid_o,
  input  wire logic                    rready_i,
  // Register side
  output logic                         wr_o,
  output logic [SPIMS_ADDR_W-1:0]      wr_addr_o,
  output logic [7:0]                   wr_data_o,
  input  wire logic                    wr_err_i,
  output logic                         rd_o,
  output logic [SPIMS_ADDR_W-1:0]      rd_addr_o,
  input  wire logic [7:0]              rd_data_i,
  input  wire logic                    rd_err_i
);
  logic aw_have_reg;
  logic w_have_reg;
  logic [SPIMS_ADDR_W-1:0] aw_reg;
  logic [7:0]              w_reg;
  logic                    w_lane_reg;

  // Ready only while clocked, so no handshake is lost while frozen
  assign awready_o = ce_i && !aw_have_reg && !bvalid_o;
  assign wready_o  = ce_i && !w_have_reg && !bvalid_o;
  assign arready_o = ce_i && !rvalid_o;
  assign wr_o      = ce_i && aw_have_reg && w_have_reg && !bvalid_o;
  assign wr_addr_o = aw_reg;
  assign wr_data_o = w_reg;
  assign rd_o      = ce_i && arvalid_i && !rvalid_o;
  assign rd_addr_o = araddr_i;

  // Capture address and data in either order; the lane 0 strobe is captured but unused, so a write without it still writes
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      aw_have_reg <= 1'b0;
      w_have_reg  <= 1'b0;
      aw_reg      <= '0;
      w_reg       <= SPIMS_RESET_BYTE;
      w_lane_reg  <= 1'b0;
      bvalid_o    <= 1'b0;
      bresp_o     <= SPIMS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (awvalid_i && awready_o)
      begin
        aw_have_reg <= 1'b1;
        aw_reg      <= awaddr_i;
      end
      if (wvalid_i && wready_o)
      begin
        w_have_reg <= 1'b1;
        w_reg      <= wdata_i[7:0];
        w_lane_reg <= wstrb_i[0];
      end
      if (wr_o)
      begin
        aw_have_reg <= 1'b0;
        w_have_reg  <= 1'b0;
        bvalid_o    <= 1'b1;
        bresp_o     <= wr_err_i ? SPIMS_RESP_SLVERR : SPIMS_RESP_OKAY;
      end
      else if (bvalid_o && bready_i)
        bvalid_o <= 1'b0;
    end
  end

  // Read answers one cycle after acceptance
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      rvalid_o <= 1'b0;
      rdata_o  <= '0;
      rresp_o  <= SPIMS_RESP_OKAY;
    end
    else if (ce_i)
    begin
      if (rd_o)
      begin
        rvalid_o <= 1'b1;
        rdata_o  <= {24'h000000, rd_data_i};
        rresp_o  <= rd_err_i ? SPIMS_RESP_SLVERR : SPIMS_RESP_OKAY;
      end
      else if (rvalid_o && rready_i)
        rvalid_o <= 1'b0;
    end
  end

  logic unused_lane;
  assign unused_lane = w_lane_reg;
endmodule : spims_axil

// >>> spims_top.sv
// SPI master/slave port with AXI4-Lite register access
//
// Local design decision: the AXI4-Lite interface to the registers.
module spims_top
  import spims_pkg::*;
(
  // Clocking
  input  wire logic                    clock_i,
  input  wire logic                    srst_i,
  input  wire logic                    ce_i,
  // AXI4-Lite write
  input  wire logic [SPIMS_ADDR_W-1:0] awaddr_i,
  input  wire logic                    awvalid_i,
  output logic                         awready_o,
  input  wire logic [31:0]             wdata_i,
  input  wire logic [3:0]              wstrb_i,
  input  wire logic                    wvalid_i,
  output logic                         wready_o,
  output logic [1:0]                   bresp_o,
  output logic                         bvalid_o,
  input  wire logic                    bready_i,
  // AXI4-Lite read
  input  wire logic [SPIMS_ADDR_W-1:0] araddr_i,
  input  wire logic                    arvalid_i,
  output logic                         arready_o,
  output logic [31:0]                  rdata_o,
  output logic [1:0]                   rresp_o,
  output logic                         rvalid_o,
  input  wire logic                    rready_i,
  // Serial pins
  input  wire spims_pkg::spims_pins_in_t  pins_i,
  output spims_pkg::spims_pins_out_t      pins_o,
  // Interrupt request
  output logic                         irq_o
);
  typedef enum logic [1:0] {ST_IDLE, ST_LEAD, ST_SHIFT} spims_state_t;

  logic [7:0] ctrl_reg;
  logic [7:0] rxbuf_reg;
  logic [7:0] shift_reg;
  logic [1:0] irqen_reg;
  logic       done_reg;
  logic       write_collision_flag_reg;
  logic       ovf_reg;
  logic       mode_fault_flag_reg;
  logic       dism_reg;
  spims_state_t state_reg;
  logic [3:0] bitcnt_reg;
  logic [6:0] div_reg;
  logic       sck_reg;
  logic       edge_reg;
  logic       mosi_reg;
  logic       sin_reg;

  // Register bus wires
  logic                    wr;
  logic [SPIMS_ADDR_W-1:0] wr_addr;
  logic [7:0]              wr_data;
  logic                    rd;
  logic [SPIMS_ADDR_W-1:0] rd_addr;
  logic [7:0]              rd_data;
  logic                    wr_err;
  logic                    rd_err;

  // Synchronised pins: sck, mosi, miso, select
  logic [3:0] pin_sync;
  logic       s_sck;
  logic       s_mosi;
  logic       s_miso;
  logic       s_ss_n;
  logic       ss_prev_reg;
  logic       sck_prev_reg;

  spims_axil u_axil (
    .clock_i   (clock_i),
    .srst_i    (srst_i),
    .ce_i      (ce_i),
    .awaddr_i  (awaddr_i),
    .awvalid_i (awvalid_i),
    .awready_o (awready_o),
    .wdata_i   (wdata_i),
    .wstrb_i   (wstrb_i),
    .wvalid_i  (wvalid_i),
    .wready_o  (wready_o),
    .bresp_o   (bresp_o),
    .bvalid_o  (bvalid_o),
    .bready_i  (bready_i),
    .araddr_i  (araddr_i),
    .arvalid_i (arvalid_i),
    .arready_o (arready_o),
    .rdata_o   (rdata_o),
    .rresp_o   (rresp_o),
    .rvalid_o  (rvalid_o),
    .rready_i  (rready_i),
    .wr_o      (wr),
    .wr_addr_o (wr_addr),
    .wr_data_o (wr_data),
    .wr_err_i  (wr_err),
    .rd_o      (rd),
    .rd_addr_o (rd_addr),
    .rd_data_i (rd_data),
    .rd_err_i  (rd_err)
  );

  spims_sync #(.WIDTH(4)) u_sync (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .ce_i    (ce_i),
    .async_i ({pins_i.sck, pins_i.mosi, pins_i.miso, pins_i.ss_n}),
    .init_i  (4'h1),
    .sync_o  (pin_sync)
  );

  assign {s_sck, s_mosi, s_miso, s_ss_n} = pin_sync;

  // Decoded configuration
  logic en;
  logic master_select;
  logic pol;
  logic pha;
  logic lsbf;
  logic select_output_enable;
  assign en   = ctrl_reg[SPIMS_C_EN];
  assign master_select = ctrl_reg[SPIMS_C_MASTER_SELECT];
  assign pol  = ctrl_reg[SPIMS_C_POL];
  assign pha  = ctrl_reg[SPIMS_C_PHA];
  assign lsbf = ctrl_reg[SPIMS_C_LSB];
  assign select_output_enable = ctrl_reg[SPIMS_C_SELECT_OUTPUT_ENABLE];

  // Address decode
  logic wr_ctrl;
  logic wr_stat;
  logic wr_data_reg;
  logic wr_misc;
  assign wr_ctrl     = wr && (wr_addr == SPIMS_ADDR_CTRL);
  assign wr_stat     = wr && (wr_addr == SPIMS_ADDR_STATUS);
  assign wr_data_reg = wr && (wr_addr == SPIMS_ADDR_DATA);
  assign wr_misc     = wr && (wr_addr == SPIMS_ADDR_MISC);
  assign wr_err = !(wr_addr == SPIMS_ADDR_CTRL || wr_addr == SPIMS_ADDR_STATUS
                    || wr_addr == SPIMS_ADDR_DATA || wr_addr == SPIMS_ADDR_MISC);
  assign rd_err = !(rd_addr == SPIMS_ADDR_CTRL || rd_addr == SPIMS_ADDR_STATUS
                    || rd_addr == SPIMS_ADDR_DATA || rd_addr == SPIMS_ADDR_MISC);

  // Read mux; data register returns the receive buffer
  always_comb
  begin
    rd_data = 8'h00;
    if (rd_addr == SPIMS_ADDR_CTRL)
      rd_data = ctrl_reg;
    else if (rd_addr == SPIMS_ADDR_STATUS)
      rd_data = {done_reg, write_collision_flag_reg, ovf_reg, mode_fault_flag_reg, dism_reg, 3'h0};
    else if (rd_addr == SPIMS_ADDR_DATA)
      rd_data = rxbuf_reg;
    else if (rd_addr == SPIMS_ADDR_MISC)
      rd_data = {6'h00, irqen_reg};
  end

  // Event decode
  logic busy;
  logic ss_active;
  logic fault_now;
  logic cfg_change;
  logic load_ok;
  logic collide;
  logic byte_end;
  logic abort_slave;
  assign busy       = (state_reg != ST_IDLE);
  assign ss_active  = !master_select && en && !s_ss_n;
  assign fault_now  = en && master_select && !dism_reg && !s_ss_n;
  // Reconfiguring live bits aborts the byte
  assign cfg_change = wr_ctrl && en &&
                      ((wr_data[SPIMS_C_LSB] != lsbf) || (wr_data[SPIMS_C_MASTER_SELECT] != master_select) ||
                       (wr_data[SPIMS_C_POL] != pol) || (wr_data[SPIMS_C_PHA] != pha) ||
                       (wr_data[1:0] != ctrl_reg[1:0]));
  // Collision: transfer running, or slave phase 0 with select low
  assign collide    = wr_data_reg && !done_reg &&
                      (busy || (ss_active && !pha));
  assign load_ok    = wr_data_reg && !done_reg && !collide;

  // Control register; fault clears mode and enable at once
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      ctrl_reg <= SPIMS_RESET_BYTE;
    else if (ce_i)
    begin
      if (wr_ctrl)
        ctrl_reg <= wr_data;
      if (fault_now)
      begin
        ctrl_reg[SPIMS_C_MASTER_SELECT] <= 1'b0;
        ctrl_reg[SPIMS_C_EN]   <= 1'b0;
      end
    end
  end

  // Interrupt enables and detection disable
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      irqen_reg <= 2'h0;
      dism_reg  <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_misc)
        irqen_reg <= wr_data[1:0];
      if (wr_stat)
        dism_reg <= wr_data[SPIMS_S_DISM];
    end
  end

  // Bit order helpers
  logic out_bit;
  assign out_bit = lsbf ? shift_reg[0] : shift_reg[7];

  // Sampled input bit depends on role
  logic in_bit;
  assign in_bit = master_select ? s_miso : s_mosi;

  // Shifter with the sampled bit entering at the far end
  logic [7:0] shift_in;
  assign shift_in = lsbf ? {in_bit, shift_reg[7:1]} : {shift_reg[6:0], in_bit};

  // Slave clock edges from the synchronised pin
  logic slv_lead;
  logic slv_trail;
  assign slv_lead  = (s_sck != sck_prev_reg) && (s_sck != pol);
  assign slv_trail = (s_sck != sck_prev_reg) && (s_sck == pol);
  assign abort_slave = !master_select && busy && s_ss_n;

  // Master divider tick: one per half serial period
  logic tick;
  assign tick = (div_reg == 7'h01);

  // Sample and shift edges: per phase for the slave, master samples on leading and shifts on trailing edges
  logic samp;
  logic shft;
  always_comb
  begin
    samp = 1'b0;
    shft = 1'b0;
    if (master_select)
    begin
      samp = (state_reg == ST_SHIFT) && tick && !edge_reg;
      shft = (state_reg == ST_SHIFT) && tick && edge_reg;
    end
    else if (busy)
    begin
      samp = pha ? slv_trail : slv_lead;
      shft = pha ? slv_lead : slv_trail;
    end
  end

  // Master ends on the trailing edge after its eighth sample (seventh with phase 1) so the last pulse completes;
  // slave ends on its eighth sample
  assign byte_end = master_select ? ((state_reg == ST_SHIFT) && tick && edge_reg &&
                            (bitcnt_reg == (pha ? SPIMS_BITS - 4'h1 : SPIMS_BITS)))
                         : (samp && (bitcnt_reg == SPIMS_BITS - 4'h1));

  // Pin history for slave edge detection
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      ss_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      ss_prev_reg  <= s_ss_n;
      sck_prev_reg <= s_sck;
    end
  end

  // Transfer engine: shifter, bit counter, state, clock generator
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      state_reg  <= ST_IDLE;
      shift_reg  <= SPIMS_RESET_BYTE;
      bitcnt_reg <= 4'h0;
      div_reg    <= 7'h00;
      sck_reg    <= 1'b0;
      edge_reg   <= 1'b0;
      mosi_reg   <= 1'b0;
      sin_reg    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (!en || cfg_change || fault_now)
      begin
        state_reg <= ST_IDLE;
        sck_reg   <= pol;
      end
      else if (abort_slave)
      begin
        // Remaining bits read as ones
        state_reg <= ST_IDLE;
        shift_reg <= lsbf ? (shift_reg >> (SPIMS_BITS - bitcnt_reg)) | (SPIMS_ONES << bitcnt_reg)
                          : (shift_reg << (SPIMS_BITS - bitcnt_reg)) | (SPIMS_ONES >> bitcnt_reg);
      end
      else
      begin
        if (load_ok)
          shift_reg <= wr_data;
        unique case (state_reg)
          ST_IDLE:
          begin
            sck_reg    <= pol;
            bitcnt_reg <= 4'h0;
            edge_reg   <= 1'b0;
            mosi_reg   <= out_bit;
            if (master_select && load_ok)
            begin
              state_reg <= ST_LEAD;
              div_reg   <= spims_half_period(ctrl_reg[1:0]);
            end
            else if (!master_select && !s_ss_n && (ss_prev_reg || pha))
              state_reg <= ST_SHIFT;
          end
          ST_LEAD:
          begin
            // Half period for first bit to settle before the first edge
            mosi_reg <= out_bit;
            div_reg  <= div_reg - 7'h01;
            if (tick)
            begin
              state_reg <= ST_SHIFT;
              div_reg   <= spims_half_period(ctrl_reg[1:0]);
            end
          end
          ST_SHIFT:
          begin
            if (master_select)
            begin
              div_reg <= tick ? spims_half_period(ctrl_reg[1:0]) : div_reg - 7'h01;
              if (tick)
              begin
                sck_reg  <= ~sck_reg;
                edge_reg <= ~edge_reg;
              end
            end
            if (samp)
            begin
              sin_reg    <= in_bit;
              bitcnt_reg <= bitcnt_reg + 4'h1;
              shift_reg  <= shift_in;
            end
            if (shft)
              mosi_reg <= out_bit;
            if (byte_end)
            begin
              // Byte finished: clock parks; master waits for next write, phase 0 slave for next select cycle, phase 1 slave stays in ST_SHIFT
              state_reg <= (!master_select && pha) ? ST_SHIFT : ST_IDLE;
              bitcnt_reg <= 4'h0;
              sck_reg    <= pol;
              edge_reg   <= 1'b0;
            end
          end
          default:
            state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Output bit follows the shifter in ST_IDLE and ST_LEAD and moves only on shift edges in ST_SHIFT, so the far end never samples a changing line
  logic data_bit;
  assign data_bit = mosi_reg;

  // Status flags; set wins over software clear
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      done_reg  <= 1'b0;
      write_collision_flag_reg  <= 1'b0;
      ovf_reg   <= 1'b0;
      mode_fault_flag_reg  <= 1'b0;
      rxbuf_reg <= SPIMS_RESET_BYTE;
    end
    else if (ce_i)
    begin
      if (wr_stat)
      begin
        done_reg <= done_reg & wr_data[SPIMS_S_DONE];
        write_collision_flag_reg <= write_collision_flag_reg & wr_data[SPIMS_S_WRITE_COLLISION_FLAG];
        ovf_reg  <= ovf_reg & wr_data[SPIMS_S_OVF];
        mode_fault_flag_reg <= mode_fault_flag_reg & wr_data[SPIMS_S_MODE_FAULT_FLAG];
      end
      if (byte_end && en && !cfg_change && !abort_slave)
      begin
        if (done_reg)
          ovf_reg <= 1'b1;
        else
        begin
          done_reg  <= 1'b1;
          rxbuf_reg <= samp ? shift_in : shift_reg;
        end
      end
      if (collide)
        write_collision_flag_reg <= 1'b1;
      if (fault_now)
        mode_fault_flag_reg <= 1'b1;
    end
  end

  // Interrupt request gated by both enables
  assign irq_o = (done_reg || ovf_reg || mode_fault_flag_reg) &&
                 irqen_reg[SPIMS_M_PIE] && irqen_reg[SPIMS_M_GIE];

  // Pin drivers; select output only with detection off and enable set
  logic ss_drive;
  assign ss_drive = en && master_select && dism_reg && select_output_enable;
  always_comb
  begin
    pins_o.sck_o   = master_select ? sck_reg : pol;
    pins_o.sck_oe  = en && master_select;
    pins_o.mosi_o  = master_select ? ((state_reg == ST_LEAD) ? out_bit : data_bit) : 1'b0;
    pins_o.mosi_oe = en && master_select;
    pins_o.miso_o  = data_bit;
    pins_o.miso_oe = ss_active;
    pins_o.ss_n_o  = !busy;
    pins_o.ss_n_oe = ss_drive;
  end

  logic unused_bits;
  assign unused_bits = sin_reg ^ mosi_reg ^ s_sck;
endmodule : spims_top

// >>> spims_chk.sv
// Checker: port-level properties of the SPI port
module spims_chk
  import spims_pkg::*;
(
  // Clocking
  input wire logic clock_i,
  input wire logic srst_i,
  // Bus answers
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  // Serial pins
  input wire spims_pkg::spims_pins_out_t pins_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  // One serial clock edge, then a select edge of a byte
  sequence s_edge;
    pins_o.sck_oe && $changed(pins_o.sck_o);
  endsequence
  sequence s_sel;
    pins_o.ss_n_oe && $fell(pins_o.ss_n_o);
  endsequence
  property p_div;
    s_edge |=> $stable(pins_o.sck_o) [*7];
  endproperty
  property p_start;
    s_sel |-> ##[1:200] s_edge;
  endproperty
  property p_stop;
    pins_o.ss_n_oe && $rose(pins_o.ss_n_o) |=> $stable(pins_o.sck_o) [*4];
  endproperty
  property p_idle;
    pins_o.ss_n_oe && pins_o.ss_n_o && $past(pins_o.ss_n_o) |-> $stable(pins_o.sck_o);
  endproperty
  property p_drv;
    pins_o.sck_oe |-> pins_o.mosi_oe && !pins_o.miso_oe;
  endproperty
  property p_rd8;
    rvalid_o |-> rdata_o[31:8] == 24'h0;
  endproperty
  // Answers stand until taken, else software loses them
  property p_bh;
    bvalid_o && !bready_i |=> bvalid_o;
  endproperty
  property p_rh;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
  endproperty
  a_div: assert property (p_div) else $error("sck half period short");
  a_start: assert property (p_start) else $error("no sck after select");
  a_stop: assert property (p_stop) else $error("sck runs after byte");
  a_idle: assert property (p_idle) else $error("sck moves while idle");
  a_drv: assert property (p_drv) else $error("master pin roles wrong");
  a_rd8: assert property (p_rd8) else $error("read upper bits set");
  a_bh: assert property (p_bh) else $error("bvalid dropped");
  a_rh: assert property (p_rh) else $error("rvalid dropped");
endmodule : spims_chk

// >>> spims_peer.sv
// Partner: SPI slave in clock format 0, most significant bit first
module spims_peer
(
  // Serial side
  input  wire logic       sck_i,
  input  wire logic       ss_n_i,
  input  wire logic       mosi_i,
  // Test side
  input  wire logic [7:0] tx_i,
  output logic            miso_o,
  output logic [7:0]      rx_o
);
  logic [7:0] sh = 8'h00;
  // Select fall loads a byte, so each byte needs its own select pulse
  always @(negedge ss_n_i) sh <= tx_i;
  // Sample on the rising edge, shift on the falling edge
  always @(posedge sck_i) if (!ss_n_i) rx_o <= {rx_o[6:0], mosi_i};
  always @(negedge sck_i) if (!ss_n_i) sh <= {sh[6:0], 1'b1};
  // Released line shows the inverse of the last bit, never a held value
  assign miso_o = ss_n_i ? ~sh[7] : sh[7];
endmodule : spims_peer

// >>> tb_top.sv
// Testbench: register access, master transfers and mode fault
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import spims_pkg::*;
  logic clock_i = 0, srst_i = 1, awvalid_i = 0, wvalid_i = 0, bready_i = 0;
  logic arvalid_i = 0, rready_i = 0, ss_drv = 1;
  logic awready_o, wready_o, bvalid_o, arready_o, rvalid_o, irq_o, miso_p;
  logic [11:0] awaddr_i = 12'h0, araddr_i = 12'h0;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  logic [1:0] bresp_o, rresp_o, rd_r, wr_r;
  logic [7:0] ptx = 8'ha5, prx, rd_d;
  int mismatches = 0, checks = 0;
  spims_pins_out_t po;
  spims_pins_in_t pi;
  // Wire levels: select from ss_drv when not driven, clock and mosi pulled down, miso from the peer when not driven
  assign pi = {po.sck_oe & po.sck_o, po.mosi_oe & po.mosi_o,
               po.miso_oe ? po.miso_o : miso_p, po.ss_n_oe ? po.ss_n_o : ss_drv};
  spims_top i_spims_top(.clock_i, .srst_i, .ce_i(1'b1), .awaddr_i, .awvalid_i, .awready_o,
    .wdata_i, .wstrb_i(4'hf), .wvalid_i, .wready_o, .bresp_o, .bvalid_o, .bready_i,
    .araddr_i, .arvalid_i, .arready_o, .rdata_o, .rresp_o, .rvalid_o, .rready_i,
    .pins_i(pi), .pins_o(po), .irq_o);
  spims_peer i_spims_peer(.sck_i(pi.sck), .ss_n_i(pi.ss_n), .mosi_i(pi.mosi), .tx_i(ptx),
    .miso_o(miso_p), .rx_o(prx));
  initial forever #50 clock_i = ~clock_i;
  task automatic ck(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s exp %h got %h", n, e, g);
    end
  endtask : ck
  // Each bus task starts on a fresh edge so no strobe is driven twice at once
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock_i);
    awaddr_i <= a;
    wdata_i <= {24'h0, d};
    {awvalid_i, wvalid_i, bready_i} <= 3'h7;
    forever
    begin
      @(posedge clock_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
      if (bvalid_o) break;
    end
    wr_r = bresp_o;
    bready_i <= 1'b0;
  endtask : wr
  task automatic rd(input logic [11:0] a);
    @(posedge clock_i);
    araddr_i <= a;
    {arvalid_i, rready_i} <= 2'h3;
    forever
    begin
      @(posedge clock_i);
      if (arready_o) arvalid_i <= 1'b0;
      if (rvalid_o) break;
    end
    rd_d = rdata_o[7:0];
    rd_r = rresp_o;
    rready_i <= 1'b0;
  endtask : rd
  // One byte; optional colliding write right behind the first
  task automatic xfer(input logic [7:0] d, input int lo, input logic c);
    int n;
    n = 0;
    wr(SPIMS_ADDR_DATA, d);
    if (c) wr(SPIMS_ADDR_DATA, ~d);
    while (po.ss_n_o) @(posedge clock_i);
    while (!po.ss_n_o)
    begin
      @(posedge clock_i);
      n++;
    end
    // Select spans the byte time plus the lead half period
    ck("span", 32'h1, 32'(n > lo && n < lo + lo / 16 + 8));
  endtask : xfer
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : stop_test
  initial
  begin
    #600000;
    mismatches++;
    stop_test;
  end
  // Status after reset and error answers on unmapped addresses
  task automatic t_regs;
    rd(SPIMS_ADDR_STATUS);
    ck("status", 32'h0, rd_d);
    rd(12'h000);
    ck("resp", SPIMS_RESP_SLVERR, rd_r);
    wr(12'h000, 8'h00);
    ck("bresp", SPIMS_RESP_SLVERR, wr_r);
  endtask : t_regs
  // Master bytes in both bit orders, a refused write and a collision
  task automatic t_master;
    wr(SPIMS_ADDR_MISC, 8'h03);
    wr(SPIMS_ADDR_STATUS, 8'h08);
    wr(SPIMS_ADDR_CTRL, 8'hd0);
    xfer(8'h3c, 128, 1'b0);
    ck("peer", 8'h3c, prx);
    rd(SPIMS_ADDR_STATUS);
    ck("status", 8'h88, rd_d);
    ck("irq", 32'h1, irq_o);
    rd(SPIMS_ADDR_DATA);
    ck("data", 8'ha5, rd_d);
    wr(SPIMS_ADDR_DATA, 8'h11);
    repeat (20) @(posedge clock_i);
    ck("select", 32'h1, po.ss_n_o);
    wr(SPIMS_ADDR_STATUS, 8'h08);
    ck("irq", 32'h0, irq_o);
    wr(SPIMS_ADDR_CTRL, 8'hf3);
    ptx <= 8'h0f;
    xfer(8'h01, 1024, 1'b1);
    ck("peer", 8'h80, prx);
    rd(SPIMS_ADDR_STATUS);
    ck("status", 8'hc8, rd_d);
    rd(SPIMS_ADDR_DATA);
    ck("data", 8'hf0, rd_d);
  endtask : t_master
  // Select pulled low by another master while detection is on
  task automatic t_fault;
    wr(SPIMS_ADDR_STATUS, 8'h00);
    wr(SPIMS_ADDR_CTRL, 8'h50);
    ss_drv <= 1'b0;
    repeat (8) @(posedge clock_i);
    rd(SPIMS_ADDR_STATUS);
    ck("status", 8'h10, rd_d);
    rd(SPIMS_ADDR_CTRL);
    ck("ctrl", 8'h00, rd_d);
    ck("irq", 32'h1, irq_o);
  endtask : t_fault
  initial
  begin
    repeat (5) @(posedge clock_i);
    srst_i <= 1'b0;
    t_regs;
    t_master;
    t_fault;
    stop_test;
  end
endmodule : tb_top
bind spims_top spims_chk i_spims_chk(.clock_i, .srst_i, .bvalid_o, .bready_i, .rvalid_o,
  .rready_i, .rdata_o, .pins_o);
